// *** alarm_hist_pkg.sv ***
/*
 Package for the alarm history snapshot recorder: register map, field
 layouts, sub codes, operation kinds and timing constants.
 Assumes a single 10 MHz control clock and a plain strobe register port.
*/
package alarm_hist_pkg;

   // Clock and time base
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   // Alarm codes
   localparam logic [7:0] ALM_OPDATA_ERR = 8'h70;

   // Sub codes for the operation data error
   localparam logic [7:0] SUB_NONE = 8'h00;
   localparam logic [7:0] SUB_TRAVEL_RANGE = 8'h01;
   localparam logic [7:0] SUB_WRAP_OFF = 8'h02;
   localparam logic [7:0] SUB_ZERO_SPEED = 8'h03;
   localparam logic [7:0] SUB_OP_SPEED = 8'h04;
   localparam logic [7:0] SUB_START_SPEED = 8'h05;
   localparam logic [7:0] SUB_PUSH_SPEED = 8'h06;
   localparam logic [7:0] SUB_PUSH_CURRENT = 8'h07;
   localparam logic [7:0] SUB_HOME_LIMIT = 8'h08;

   // Travel limit magnitude
   localparam logic signed [39:0] TRAVEL_MAX = 40'sh007FFFFFFF;

   // Register word offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_SEL = 8'h08;
   localparam logic [7:0] REG_CODE = 8'h0C;
   localparam logic [7:0] REG_TEMPS = 8'h10;
   localparam logic [7:0] REG_VOLT = 8'h14;
   localparam logic [7:0] REG_DIN = 8'h18;
   localparam logic [7:0] REG_ROUT = 8'h1C;
   localparam logic [7:0] REG_OPINFO = 8'h20;
   localparam logic [7:0] REG_FBPOS = 8'h24;
   localparam logic [7:0] REG_T_BOOT = 8'h28;
   localparam logic [7:0] REG_T_MOVE = 8'h2C;
   localparam logic [7:0] REG_T_MAIN = 8'h30;
   localparam logic [7:0] REG_SEQ = 8'h34;

   // Control register fields
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_MECH_FOLLOW_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Kinds of operation, reported as numerals
   typedef enum logic [3:0] {
      OPK_NONE, OPK_POSITION, OPK_CONTINUOUS, OPK_PUSH, OPK_HOME, OPK_JOG, OPK_WRAP
   } op_kind_t;

   // Live operating state supplied by the drive
   typedef struct packed {
      logic [15:0] drv_temp;
      logic [15:0] mot_temp;
      logic [15:0] inv_volt;
      logic [15:0] din;
      logic [15:0] rout;
      logic [7:0] op_num;
      op_kind_t op_kind;
      logic [31:0] fb_pos;
   } live_t;

   // Operation start request checked for the data error
   typedef struct packed {
      logic signed [39:0] travel;
      logic [31:0] op_speed;
      logic [31:0] start_speed;
      logic [31:0] push_speed;
      logic [15:0] push_current;
      logic home_over;
      logic needs_wrap;
   } op_req_t;

   // Limits held in the sensor
   typedef struct packed {
      logic [31:0] max_op_speed;
      logic [31:0] max_start_speed;
      logic [31:0] max_push_speed;
      logic [15:0] max_push_current;
   } mech_lim_t;

   // One stored history entry
   typedef struct packed {
      logic [15:0] seq;
      logic [7:0] code;
      logic [7:0] sub;
      live_t live;
      logic [31:0] t_boot;
      logic [31:0] t_move;
      logic [31:0] t_main;
   } entry_t;

endpackage : alarm_hist_pkg

// *** alarm_history_recorder.sv ***
/*
 Alarm history snapshot recorder: classifies operation data errors, keeps
 three millisecond time counters, and stores a snapshot per alarm into a
 ring of entries read over a plain strobe register port.
 Assumes all inputs are synchronous to CLK; alarm events are one-cycle pulses.
*/
`timescale 1ns/1ns

module alarm_history_recorder
   import alarm_hist_pkg::*;
#(
   parameter int DEPTH = 10,
   parameter int TICK = TICK_CYCLES
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Power state
   input wire logic CTRL_SUPPLY_ON,
   input wire logic CTRL_SUPPLY_PRESENT,
   input wire logic MAIN_SUPPLY_ON,
   // Alarm events
   input wire logic ALARM_EVENT,
   input wire logic [7:0] ALARM_CODE,
   input wire logic [7:0] ALARM_CHECK_CODE,
   // Live drive state
   input wire live_t LIVE,
   input wire logic [15:0] ROUT_SET,
   input wire logic [15:0] ROUT_CLR,
   // Operation start check
   input wire logic OP_START,
   input wire op_req_t OP_REQ,
   input wire logic WRAP_ENABLED,
   input wire mech_lim_t MECH_LIM,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Operation data error report
   output logic OPDATA_ERR,
   output logic [7:0] OPDATA_SUB
);

   localparam int IW = $clog2(DEPTH);

   // Count must fit the top byte of the status word
   if (DEPTH < 2 || DEPTH > 255) begin : g_bad_depth
      $error("DEPTH out of range");
   end
   if (TICK < 1) begin : g_bad_tick
      $error("TICK must be at least one");
   end

   entry_t hist [DEPTH];
   logic [IW-1:0] wr_idx;
   logic [IW:0] count;
   logic [IW-1:0] sel;
   logic [15:0] seq;
   logic [31:0] ctrl;
   logic [15:0] rout_img;
   logic [31:0] t_boot, t_move, t_main;
   logic [$clog2(TICK+1)-1:0] tick_cnt;
   logic tick;
   logic moving;
   logic [7:0] next_sub;
   logic [7:0] last_sub;
   logic [IW-1:0] rd_idx;
   entry_t ent;
   logic hist_clr;
   logic [IW-1:0] slot;
   logic [15:0] slot_seq;

   // Millisecond tick shared by all three timers
   always_ff @(posedge CLK) begin
      if (RST || tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end
   assign tick = (tick_cnt == ($clog2(TICK+1))'(TICK - 1));

   // Boot timer runs from the control supply, or main supply if none fitted
   always_ff @(posedge CLK) begin
      if (RST) begin
         t_boot <= 32'h0000_0000;
      end else if (CTRL_SUPPLY_PRESENT ? !CTRL_SUPPLY_ON : !MAIN_SUPPLY_ON) begin
         t_boot <= 32'h0000_0000;
      end else if (tick && t_boot != 32'hFFFF_FFFF) begin
         t_boot <= t_boot + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST || !MAIN_SUPPLY_ON) begin
         t_main <= 32'h0000_0000;
      end else if (tick && t_main != 32'hFFFF_FFFF) begin
         t_main <= t_main + 1'b1;
      end
   end

   // Move timer restarts on every operation start
   always_ff @(posedge CLK) begin
      if (RST) begin
         t_move <= 32'h0000_0000;
         moving <= 1'b0;
      end else if (OP_START) begin
         t_move <= 32'h0000_0000;
         moving <= 1'b1;
      end else if (tick && moving && t_move != 32'hFFFF_FFFF) begin
         t_move <= t_move + 1'b1;
      end
   end

   // Remote output image kept even with no network attached
   always_ff @(posedge CLK) begin
      if (RST) begin
         rout_img <= 16'h0000;
      end else begin
         rout_img <= (rout_img | ROUT_SET) & ~ROUT_CLR;
      end
   end

   // Cause classification; first failing check in sub code order wins
   always_comb begin
      next_sub = SUB_NONE;
      if (OP_REQ.travel > TRAVEL_MAX || OP_REQ.travel < -TRAVEL_MAX) begin
         next_sub = SUB_TRAVEL_RANGE;
      end else if (OP_REQ.needs_wrap && !WRAP_ENABLED) begin
         next_sub = SUB_WRAP_OFF;
      end else if (OP_REQ.travel != 40'sh0 && OP_REQ.op_speed == 32'h0000_0000) begin
         next_sub = SUB_ZERO_SPEED;
      end else if (ctrl[CTRL_MECH_FOLLOW_BIT]) begin
         if (OP_REQ.op_speed > MECH_LIM.max_op_speed) begin
            next_sub = SUB_OP_SPEED;
         end else if (OP_REQ.start_speed > MECH_LIM.max_start_speed) begin
            next_sub = SUB_START_SPEED;
         end else if (OP_REQ.push_speed > MECH_LIM.max_push_speed) begin
            next_sub = SUB_PUSH_SPEED;
         end else if (OP_REQ.push_current > MECH_LIM.max_push_current) begin
            next_sub = SUB_PUSH_CURRENT;
         end else if (OP_REQ.home_over) begin
            next_sub = SUB_HOME_LIMIT;
         end
      end
   end

   // Error report pulse and remembered cause for the next alarm 70h
   always_ff @(posedge CLK) begin
      if (RST) begin
         OPDATA_ERR <= 1'b0;
         OPDATA_SUB <= SUB_NONE;
         last_sub <= SUB_NONE;
      end else begin
         OPDATA_ERR <= OP_START && (next_sub != SUB_NONE);
         if (OP_START && next_sub != SUB_NONE) begin
            OPDATA_SUB <= next_sub;
            last_sub <= next_sub;
         end
      end
   end

   // Software clear; an alarm in the clearing cycle is kept as the first entry
   assign hist_clr = REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_CLEAR_BIT];
   assign slot = hist_clr ? '0 : wr_idx;
   assign slot_seq = hist_clr ? 16'h0000 : seq;

   // Snapshot store: ring of entries, sequence number orders them
   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_idx <= '0;
         count <= '0;
         seq <= 16'h0000;
      end else if (ALARM_EVENT) begin
         wr_idx <= (slot == IW'(DEPTH - 1)) ? '0 : slot + 1'b1;
         if (hist_clr) begin
            count <= (IW+1)'(1);
         end else if (count != (IW+1)'(DEPTH)) begin
            count <= count + 1'b1;
         end
         seq <= slot_seq + 1'b1;
      end else if (hist_clr) begin
         wr_idx <= '0;
         count <= '0;
         seq <= 16'h0000;
      end
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge CLK) begin
         if (RST) begin
            hist[i] <= '0;
         end else if (ALARM_EVENT && slot == IW'(i)) begin
            hist[i].seq <= slot_seq;
            hist[i].code <= ALARM_CODE;
            hist[i].sub <= (ALARM_CODE == ALM_OPDATA_ERR) ? last_sub : ALARM_CHECK_CODE;
            hist[i].live <= LIVE;
            hist[i].live.rout <= rout_img;
            hist[i].t_boot <= t_boot;
            hist[i].t_move <= t_move;
            hist[i].t_main <= t_main;
         end
      end
   end

   // Control and selector registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl <= CTRL_RESET;
         sel <= '0;
      end else if (REG_WR) begin
         if (REG_ADDR == REG_CTRL) begin
            ctrl <= REG_WDATA & 32'h0000_0002;
         end
         if (REG_ADDR == REG_SEL && REG_WDATA < DEPTH) begin
            sel <= REG_WDATA[IW-1:0];
         end
      end
   end

   // Selector 0 is the newest entry, higher values go back in time
   always_comb begin
      rd_idx = (wr_idx >= sel + 1'b1) ? IW'(wr_idx - sel - 1'b1)
                                      : IW'(DEPTH + wr_idx - sel - 1);
      ent = hist[rd_idx];
   end

   // Read data valid in the cycle after the strobe only
   always_ff @(posedge CLK) begin
      if (RST || !REG_RD) begin
         REG_RDATA <= 32'h0000_0000;
      end else begin
         case (REG_ADDR)
            REG_CTRL: REG_RDATA <= ctrl;
            REG_STATUS: REG_RDATA <= {16'h0000, seq[15:0]} | (32'((count)) << 24);
            REG_SEL: REG_RDATA <= 32'(sel);
            REG_CODE: REG_RDATA <= {16'h0000, ent.code, ent.sub};
            REG_TEMPS: REG_RDATA <= {ent.live.drv_temp, ent.live.mot_temp};
            REG_VOLT: REG_RDATA <= {16'h0000, ent.live.inv_volt};
            REG_DIN: REG_RDATA <= {16'h0000, ent.live.din};
            REG_ROUT: REG_RDATA <= {16'h0000, ent.live.rout};
            REG_OPINFO: REG_RDATA <= {20'h00000, ent.live.op_kind, ent.live.op_num};
            REG_FBPOS: REG_RDATA <= ent.live.fb_pos;
            REG_T_BOOT: REG_RDATA <= ent.t_boot;
            REG_T_MOVE: REG_RDATA <= ent.t_move;
            REG_T_MAIN: REG_RDATA <= ent.t_main;
            REG_SEQ: REG_RDATA <= {16'h0000, ent.seq};
            default: REG_RDATA <= 32'h0000_0000;
         endcase
      end
   end

endmodule : alarm_history_recorder

// *** alarm_history_recorder_bench.sv ***
/*
 Self-checking bench for the alarm history recorder, random with corners.
 Assumes the host model drives the register port; timers shortened by TICK.
*/
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value %s exp %h got %h", nm, e, a); end end
module alarm_history_recorder_bench;
   import alarm_hist_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ctrl_on = 1'b0, present = 1'b0, main_on = 1'b0;
   logic alarm = 1'b0, op_start = 1'b0, wrap_en = 1'b1, err;
   logic [7:0] code = 8'h00, chkc = 8'h00, sub, addr;
   logic [15:0] rset = 16'h0, rclr = 16'h0;
   logic [31:0] wdata, rdata, tm, tb, tv, s0;
   logic [127:0] rnd;
   logic wr, rd;
   live_t live = '0, lv;
   op_req_t op_req = '0;
   mech_lim_t lim = '{32'h400, 32'h400, 32'h400, 16'h400};
   int miscompares = 0, n_tests = 0;
   alarm_history_recorder #(.DEPTH(10), .TICK(4)) dut (.CLK(clk), .RST(rst),
      .CTRL_SUPPLY_ON(ctrl_on), .CTRL_SUPPLY_PRESENT(present), .MAIN_SUPPLY_ON(main_on),
      .ALARM_EVENT(alarm), .ALARM_CODE(code), .ALARM_CHECK_CODE(chkc), .LIVE(live),
      .ROUT_SET(rset), .ROUT_CLR(rclr), .OP_START(op_start), .OP_REQ(op_req),
      .WRAP_ENABLED(wrap_en), .MECH_LIM(lim), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .OPDATA_ERR(err), .OPDATA_SUB(sub));
   host_reader host (.CLK(clk), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
      .REG_RD(rd), .REG_RDATA(rdata));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic raise(input logic [7:0] c);
      @(posedge clk);
      alarm <= 1'b1;
      code <= c;
      chkc <= 8'($urandom);
      @(posedge clk);
      alarm <= 1'b0;
   endtask : raise
   task automatic op(input int k);
      op_req_t q;
      logic w;
      q = '{40'sd0, 32'h10, 32'h10, 32'h10, 16'h10, 1'b0, 1'b0};
      q.travel = 40'($urandom_range(1, 1000));
      w = 1'b1;
      case (k)
         1: q.travel = 40'sh0080000000;
         2: begin q.needs_wrap = 1'b1; w = 1'b0; end
         3: q.op_speed = 32'h0;
         4: q.op_speed = 32'h7FF;
         5: q.start_speed = 32'h7FF;
         6: q.push_speed = 32'h7FF;
         7: q.push_current = 16'h7FF;
         8: q.home_over = 1'b1;
         default: ;
      endcase
      @(posedge clk);
      op_req <= q;
      wrap_en <= w;
      op_start <= 1'b1;
      @(posedge clk);
      op_start <= 1'b0;
   endtask : op
   task automatic chkreg(input string nm, input logic [7:0] a, input logic [31:0] e);
      host.rd(a, s0);
      `CHK(nm, e, s0)
   endtask : chkreg
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end
   initial begin
      void'($urandom(84293));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      main_on <= 1'b1;
      op(0);
      repeat (40) @(posedge clk);
      raise(8'h30);
      host.rd(REG_T_MAIN, tm);
      host.rd(REG_T_BOOT, tb);
      host.rd(REG_T_MOVE, tv);
      `CHK("t_main", 1'b1, tm >= 9 && tm <= 12)
      `CHK("t_move", 1'b1, tv >= 9 && tv <= 11)
      `CHK("t_boot", tm, tb)
      // Fitted control supply seen off for one cycle, so the boot timer restarts
      present <= 1'b1;
      @(posedge clk);
      ctrl_on <= 1'b1;
      repeat (20) @(posedge clk);
      raise(8'h31);
      host.rd(REG_T_BOOT, tb);
      `CHK("t_boot", 1'b1, tb >= 4 && tb <= 7)
      $display("timers done");
      for (int i = 0; i < 3; i++) begin
         rnd = {$urandom, $urandom, $urandom, $urandom};
         lv = rnd[$bits(live_t)-1:0];
         lv.op_kind = op_kind_t'(i + 1);
         live <= lv;
         raise(8'h40 + 8'(i));
         chkreg("code", REG_CODE, {16'h0, 8'h40 + 8'(i), chkc});
         chkreg("temps", REG_TEMPS, {lv.drv_temp, lv.mot_temp});
         chkreg("volt", REG_VOLT, {16'h0, lv.inv_volt});
         chkreg("din", REG_DIN, {16'h0, lv.din});
         chkreg("opinfo", REG_OPINFO, {20'h0, lv.op_kind, lv.op_num});
         chkreg("fbpos", REG_FBPOS, lv.fb_pos);
      end
      host.rd(REG_SEQ, tm);
      host.wr(REG_SEL, 32'h1);
      chkreg("seq", REG_SEQ, tm - 32'h1);
      host.wr(REG_SEL, 32'h0);
      $display("snapshot done");
      tm = $urandom;
      rset <= tm[15:0];
      @(posedge clk);
      rset <= tm[31:16];
      rclr <= 16'h00FF;
      @(posedge clk);
      rset <= 16'h0;
      rclr <= 16'h0;
      raise(8'h50);
      chkreg("rout", REG_ROUT, {16'h0, (tm[15:0] | tm[31:16]) & 16'hFF00});
      $display("remote image done");
      host.wr(REG_CTRL, 32'h2);
      for (int k = 0; k < 9; k++) begin
         op(k);
         @(posedge clk);
         `CHK("err", k != 0, err)
         if (k != 0) `CHK("sub", 8'(k), sub)
      end
      raise(ALM_OPDATA_ERR);
      chkreg("code70", REG_CODE, {16'h0, ALM_OPDATA_ERR, SUB_HOME_LIMIT});
      chkreg("status", REG_STATUS, 32'h0700_0007);
      host.wr(REG_SEL, 32'hA);
      chkreg("sel", REG_SEL, 32'h0);
      host.wr(REG_CTRL, 32'h1);
      chkreg("status_clr", REG_STATUS, 32'h0);
      op(4);
      @(posedge clk);
      `CHK("err_nofollow", 1'b0, err)
      $display("sub codes done");
      end_sim();
   end
endmodule : alarm_history_recorder_bench

// *** alarm_history_recorder_monitor.sv ***
/*
 Checker for the operation data error report and the register read port.
 Assumes it is bound to the recorder top; sees only its ports.
*/
`timescale 1ns/1ns
module alarm_history_recorder_monitor
   import alarm_hist_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Operation check
   input wire logic OP_START,
   input wire op_req_t OP_REQ,
   input wire logic WRAP_ENABLED,
   input wire mech_lim_t MECH_LIM,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   // Report
   input wire logic OPDATA_ERR,
   input wire logic [7:0] OPDATA_SUB
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   logic follow;
   logic [7:0] chk;
   function automatic logic [7:0] esub(op_req_t q, logic w, mech_lim_t m, logic f);
      if (q.travel > TRAVEL_MAX || q.travel < -TRAVEL_MAX) return SUB_TRAVEL_RANGE;
      if (q.needs_wrap && !w) return SUB_WRAP_OFF;
      if (q.travel != 0 && q.op_speed == 0) return SUB_ZERO_SPEED;
      if (!f) return SUB_NONE;
      if (q.op_speed > m.max_op_speed) return SUB_OP_SPEED;
      if (q.start_speed > m.max_start_speed) return SUB_START_SPEED;
      if (q.push_speed > m.max_push_speed) return SUB_PUSH_SPEED;
      if (q.push_current > m.max_push_current) return SUB_PUSH_CURRENT;
      if (q.home_over) return SUB_HOME_LIMIT;
      return SUB_NONE;
   endfunction : esub
   // Shadow of the limit-follow control bit
   always_ff @(posedge CLK) begin
      if (RST) follow <= 1'b0;
      else if (REG_WR && REG_ADDR == REG_CTRL) follow <= REG_WDATA[CTRL_MECH_FOLLOW_BIT];
   end
   assign chk = esub(OP_REQ, WRAP_ENABLED, MECH_LIM, follow);
   property p_travel; OP_START && chk == SUB_TRAVEL_RANGE |=> OPDATA_ERR && OPDATA_SUB == 8'h01; endproperty
   a_travel: assert property (p_travel) else $error("travel sub code wrong");
   property p_wrap; OP_START && chk == SUB_WRAP_OFF |=> OPDATA_ERR && OPDATA_SUB == 8'h02; endproperty
   a_wrap: assert property (p_wrap) else $error("wrap sub code wrong");
   property p_zspeed; OP_START && chk == SUB_ZERO_SPEED |=> OPDATA_ERR && OPDATA_SUB == 8'h03; endproperty
   a_zspeed: assert property (p_zspeed) else $error("zero speed sub code wrong");
   property p_lim; OP_START && chk >= SUB_OP_SPEED |=> OPDATA_ERR && OPDATA_SUB == $past(chk); endproperty
   a_lim: assert property (p_lim) else $error("limit sub code wrong");
   property p_noerr; OP_START && chk == SUB_NONE |=> !OPDATA_ERR; endproperty
   a_noerr: assert property (p_noerr) else $error("error flagged on clean start");
   property p_pulse; OPDATA_ERR |-> $past(OP_START); endproperty
   a_pulse: assert property (p_pulse) else $error("error pulse without start");
   property p_drop; !OP_START |=> !OPDATA_ERR; endproperty
   a_drop: assert property (p_drop) else $error("error pulse longer than its start");
   property p_hold; !OPDATA_ERR |-> $stable(OPDATA_SUB); endproperty
   a_hold: assert property (p_hold) else $error("sub code changed without error");
   property p_rd_idle; !REG_RD |=> REG_RDATA == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   c_err: cover property (OPDATA_ERR);
   c_lim: cover property (OP_START && chk >= SUB_OP_SPEED);
   c_rd: cover property (REG_RD ##1 REG_RDATA != 32'h0);
endmodule : alarm_history_recorder_monitor
bind alarm_history_recorder alarm_history_recorder_monitor u_mon (.CLK(CLK), .RST(RST),
   .OP_START(OP_START), .OP_REQ(OP_REQ), .WRAP_ENABLED(WRAP_ENABLED), .MECH_LIM(MECH_LIM),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .OPDATA_ERR(OPDATA_ERR), .OPDATA_SUB(OPDATA_SUB));

// *** host_reader.sv ***
/*
 Host side model: setup software reading history over the register port.
 Assumes the slave answers reads one cycle later and never stalls.
*/
`timescale 1ns/1ns
module host_reader (
   // Clock
   input wire logic CLK,
   // Register port
   output logic [7:0] REG_ADDR = 8'h00,
   output logic [31:0] REG_WDATA = 32'h0,
   output logic REG_WR = 1'b0,
   output logic REG_RD = 1'b0,
   input wire logic [31:0] REG_RDATA
);
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
      // Stale data is not left on the bus
      REG_WDATA <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      @(posedge CLK);
      d = REG_RDATA;
   endtask : rd
endmodule : host_reader
